// ==== hw/pin_function_control_map.vh ====
// constants for the pin function control block: offsets, fields, resets
// assumes a 32-bit AHB-Lite register bus with word-aligned registers
//
// Behaviour
// - bits 15..13 reserved, write zero, read zero
// - mux control drives pins zero/one as select
// - external mux sequencing covers at most four channels
// - optional settling delay after each mux switch
// - sync enable: low pin holds converter reset
// - alternate sync needs several channels, no reset
// - alternate sync: low pin withholds next conversion
// - error field 00 disables pin error role
// - error input: inverted pin ORed into error
// - error output: ORed errors, inverted, open-drain
// - general output drives pin high and low
// - error level bit drives or reports pin
// - pin one input enable makes pin readable
// - register at 0x06, resets to 0x0800
// - bits 3,2 enable outputs of pins one, zero
// - bits 1,0 write or read pin levels
`ifndef PIN_FUNCTION_CONTROL_MAP_VH
`define PIN_FUNCTION_CONTROL_MAP_VH

// register indices on HADDR[7:2]; byte address is four times the index
`define PFC_IDX_CONTROL    6'h06
`define PFC_IDX_SEQ        6'h08
`define PFC_IDX_STATUS     6'h0C
`define PFC_IDX_MASK       6'h10

`define PFC_RESET_CONTROL  16'h0800
`define PFC_RESET_CH_EN    4'h1
`define PFC_RESET_DELAY    8'h00
`define PFC_RESERVED_MASK  16'hE000

`define PFC_BIT_MUX        12
`define PFC_BIT_SYNC_EN    11
`define PFC_ERR_HI         10
`define PFC_ERR_LO         9
`define PFC_BIT_ERR_LEVEL  8
`define PFC_BIT_IN_EN1     5
`define PFC_BIT_IN_EN0     4
`define PFC_BIT_OUT_EN1    3
`define PFC_BIT_OUT_EN0    2
`define PFC_BIT_LEVEL1     1
`define PFC_BIT_LEVEL0     0

`define PFC_ERR_OFF        2'b00
`define PFC_ERR_INPUT      2'b01
`define PFC_ERR_OUTPUT     2'b10
`define PFC_ERR_GPO        2'b11

// sequencer control register fields
`define PFC_BIT_ALTERNATE_SYNC_SELECT   0
`define PFC_CH_EN_LO       4
`define PFC_CH_EN_HI       7
`define PFC_DELAY_LO       8
`define PFC_DELAY_HI       15
`define PFC_BIT_SWITCH     16

// interrupt status bits
`define PFC_IRQ_SWITCH     0
`define PFC_IRQ_ERROR      1
`define PFC_IRQ_SYNC_HOLD  2
`define PFC_IRQ_W          3

`endif

// ==== hw/pfc_sync2.v ====
// two-stage level synchroniser for one pin input
// assumes a single clock and synchronous active-low reset
`timescale 1ns/100ps
module pfc_sync2
(
  input  wire clk,
  input  wire rst_n,
  input  wire d,
  output reg  q
);
  reg meta;

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta <= 1'b0;
      q    <= 1'b0;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// ==== hw/pfc_delay.v ====
// settling-delay counter started at each external mux switch
// assumes one clock; a zero length makes done follow start by one cycle
`timescale 1ns/100ps
module pfc_delay
(
  input  wire       clk,
  input  wire       rst_n,
  input  wire       start,
  input  wire [7:0] length,
  output reg        busy
);
  reg [7:0] count;

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      busy  <= 1'b0;
      count <= 8'h00;
    end
    else if (start)
    begin
      busy  <= 1'b1;
      count <= length;
    end
    else if (busy)
    begin
      if (count == 8'h00)
        busy <= 1'b0;
      else
        count <= count - 8'h01;
    end
  end
endmodule

// ==== hw/pin_function_control.v ====
// pin function control: aux pin routing behind an AHB-Lite slave
// assumes the channel sequencer's switch requests arrive via register
// or the SWITCH_REQ input; error sources come from the status logic
`timescale 1ns/100ps
`include "pin_function_control_map.vh"
module pin_function_control
(
  input  wire        CLK,
  input  wire        RST_N,
  input  wire        HSEL,
  input  wire [31:0] HADDR,
  input  wire [1:0]  HTRANS,
  input  wire        HWRITE,
  input  wire [2:0]  HSIZE,
  input  wire [31:0] HWDATA,
  input  wire        HREADY,
  output reg  [31:0] HRDATA,
  output reg         HREADYOUT,
  output reg         HRESP,
  input  wire        SWITCH_REQ,
  input  wire        STATUS_ERR,
  input  wire        GP0_IN,
  output reg         GP0_OUT,
  output reg         GP0_OE_N,
  input  wire        GP1_IN,
  output reg         GP1_OUT,
  output reg         GP1_OE_N,
  input  wire        SYNC_ERR_IN,
  output reg         SYNC_ERR_OUT,
  output reg         SYNC_ERR_OE_N,
  output reg         CONV_HOLD,
  output reg         CONV_START,
  output reg         CONVERTER_ERROR,
  output reg  [1:0]  CHANNEL,
  output reg         IRQ
);
  reg  [15:0] control;
  reg         alternate_sync_select;
  reg  [3:0]  channel_enable;
  reg  [7:0]  settle_delay;
  reg  [2:0]  irq_status;
  reg  [2:0]  irq_mask;
  reg         wr_pending;
  // index of the register whose data phase is running
  reg  [5:0]  addr_q;
  reg         sw_req_reg;
  reg         wait_sync;
  reg  [1:0]  mux_sel;
  reg         start_pending;
  wire        gp0_sync;
  wire        gp1_sync;
  wire        sync_pin;
  wire        delay_busy;
  wire        delay_start;
  wire [1:0]  err_mode;
  wire        multi_channel;
  wire        switch_due;
  wire        err_in_flag;
  wire        addr_phase;
  wire        switch_ok;
  wire        status_read;
  reg  [1:0]  next_channel;
  reg  [2:0]  ch_count;
  integer     i;
  integer     j;

  pfc_sync2 u_sync_gp0
  (
    .clk   (CLK),
    .rst_n (RST_N),
    .d     (GP0_IN),
    .q     (gp0_sync)
  );

  pfc_sync2 u_sync_gp1
  (
    .clk   (CLK),
    .rst_n (RST_N),
    .d     (GP1_IN),
    .q     (gp1_sync)
  );

  pfc_sync2 u_sync_pin
  (
    .clk   (CLK),
    .rst_n (RST_N),
    .d     (SYNC_ERR_IN),
    .q     (sync_pin)
  );

  pfc_delay u_settle
  (
    .clk    (CLK),
    .rst_n  (RST_N),
    .start  (delay_start),
    .length (settle_delay),
    .busy   (delay_busy)
  );

  assign err_mode    = control[`PFC_ERR_HI:`PFC_ERR_LO];
  assign addr_phase  = HSEL & HTRANS[1] & HREADY;
  assign switch_due  = SWITCH_REQ | sw_req_reg;
  // one switch at a time: later requests are dropped, not kept, until this one's start
  assign switch_ok   = switch_due & ~wait_sync & ~delay_busy
                       & ~start_pending;
  // clear on the address phase, the edge that samples the status,
  // so an event landing in the data phase is kept for the next read
  assign status_read = addr_phase & ~HWRITE
                       & (HADDR[7:2] == `PFC_IDX_STATUS);
  // sync pin is an error input only in error mode 01; mode 00 ignores it
  assign err_in_flag = (err_mode == `PFC_ERR_INPUT) & ~sync_pin;

  // only the four low channels take part in automatic sequencing
  always @*
  begin
    ch_count = 3'h0;
    for (i = 0; i < 4; i = i + 1)
      ch_count = ch_count + {2'b00, channel_enable[i]};
  end
  assign multi_channel = (ch_count > 3'h1);

  // next enabled channel after the current one, wrapping within four
  always @*
  begin
    next_channel = mux_sel;
    for (j = 3; j >= 1; j = j - 1)
      if (channel_enable[(mux_sel + j) % 4])
        next_channel = mux_sel + j[1:0];
  end

  // settling runs from every mux switch, also across a sync wait
  assign delay_start = switch_ok & control[`PFC_BIT_MUX];

  // bus slave: zero wait states, always OKAY
  always @(posedge CLK)
  begin
    if (!RST_N)
    begin
      wr_pending <= 1'b0;
      addr_q     <= 6'h00;
      HREADYOUT  <= 1'b1;
      HRESP      <= 1'b0;
      HRDATA     <= 32'h00000000;
    end
    else
    begin
      wr_pending <= addr_phase & HWRITE;
      if (addr_phase)
        addr_q <= HADDR[7:2];
      // read data is zero outside a read data phase
      HRDATA <= 32'h00000000;
      if (addr_phase & ~HWRITE)
      begin
        case (HADDR[7:2])
          `PFC_IDX_CONTROL:
          begin
            HRDATA[15:0] <= control & ~`PFC_RESERVED_MASK;
            if (err_mode != `PFC_ERR_GPO)
              HRDATA[`PFC_BIT_ERR_LEVEL] <= sync_pin;
            if (control[`PFC_BIT_IN_EN1])
              HRDATA[`PFC_BIT_LEVEL1] <= gp1_sync;
            if (control[`PFC_BIT_IN_EN0])
              HRDATA[`PFC_BIT_LEVEL0] <= gp0_sync;
          end
          `PFC_IDX_SEQ:
            HRDATA[15:0] <= {settle_delay, channel_enable,
                             3'b000, alternate_sync_select};
          `PFC_IDX_STATUS:
            HRDATA[2:0] <= irq_status;
          `PFC_IDX_MASK:
            HRDATA[2:0] <= irq_mask;
          default:
            HRDATA <= 32'h00000000;
        endcase
      end
    end
  end

  // registers written in the data phase
  always @(posedge CLK)
  begin
    if (!RST_N)
    begin
      control        <= `PFC_RESET_CONTROL;
      alternate_sync_select       <= 1'b0;
      channel_enable <= `PFC_RESET_CH_EN;
      settle_delay   <= `PFC_RESET_DELAY;
      irq_mask       <= 3'b000;
      sw_req_reg     <= 1'b0;
    end
    else
    begin
      sw_req_reg <= 1'b0;
      if (wr_pending)
      begin
        case (addr_q)
          `PFC_IDX_CONTROL:
            control <= HWDATA[15:0] & ~`PFC_RESERVED_MASK;
          `PFC_IDX_SEQ:
          begin
            alternate_sync_select       <= HWDATA[`PFC_BIT_ALTERNATE_SYNC_SELECT];
            channel_enable <= HWDATA[`PFC_CH_EN_HI:`PFC_CH_EN_LO];
            settle_delay   <= HWDATA[`PFC_DELAY_HI:`PFC_DELAY_LO];
            sw_req_reg     <= HWDATA[`PFC_BIT_SWITCH];
          end
          `PFC_IDX_MASK:
            irq_mask <= HWDATA[2:0];
          default:
            irq_mask <= irq_mask;
        endcase
      end
    end
  end

  // sequencing, sync gating and mux select
  always @(posedge CLK)
  begin
    if (!RST_N)
    begin
      mux_sel       <= 2'b00;
      wait_sync     <= 1'b0;
      start_pending <= 1'b0;
      CONV_START    <= 1'b0;
      CONV_HOLD     <= 1'b0;
      CHANNEL       <= 2'b00;
    end
    else
    begin
      CONV_START <= 1'b0;
      // plain sync: low pin holds converter; alternate mode with several channels never does
      CONV_HOLD <= control[`PFC_BIT_SYNC_EN] & ~sync_pin
                   & ~(alternate_sync_select & multi_channel);
      if (switch_ok)
      begin
        mux_sel <= next_channel;
        CHANNEL <= next_channel;
        if (control[`PFC_BIT_SYNC_EN] & alternate_sync_select & multi_channel
            & ~sync_pin)
          wait_sync <= 1'b1;
        else if (control[`PFC_BIT_MUX])
          start_pending <= 1'b1;
        else
          CONV_START <= 1'b1;
      end
      // settle was armed at the switch; start_pending waits for it
      if (wait_sync & sync_pin)
      begin
        wait_sync <= 1'b0;
        if (control[`PFC_BIT_MUX])
          start_pending <= 1'b1;
        else
          CONV_START <= 1'b1;
      end
      // delay is armed in the switch cycle, with start_pending; wait till it ends
      if (start_pending & ~delay_busy & ~delay_start)
      begin
        start_pending <= 1'b0;
        CONV_START    <= 1'b1;
      end
    end
  end

  // pins and error output
  always @(posedge CLK)
  begin
    if (!RST_N)
    begin
      GP0_OUT         <= 1'b0;
      GP0_OE_N        <= 1'b1;
      GP1_OUT         <= 1'b0;
      GP1_OE_N        <= 1'b1;
      SYNC_ERR_OUT    <= 1'b1;
      SYNC_ERR_OE_N   <= 1'b1;
      CONVERTER_ERROR <= 1'b0;
    end
    else
    begin
      if (control[`PFC_BIT_MUX])
      begin
        GP0_OUT  <= mux_sel[0];
        GP0_OE_N <= 1'b0;
        GP1_OUT  <= mux_sel[1];
        GP1_OE_N <= 1'b0;
      end
      else
      begin
        GP0_OUT  <= control[`PFC_BIT_LEVEL0];
        GP0_OE_N <= ~control[`PFC_BIT_OUT_EN0];
        GP1_OUT  <= control[`PFC_BIT_LEVEL1];
        GP1_OE_N <= ~control[`PFC_BIT_OUT_EN1];
      end
      CONVERTER_ERROR <= STATUS_ERR | err_in_flag;
      case (err_mode)
        `PFC_ERR_OFF:
        begin
          SYNC_ERR_OUT  <= 1'b1;
          SYNC_ERR_OE_N <= 1'b1;
        end
        `PFC_ERR_INPUT:
        begin
          SYNC_ERR_OUT  <= 1'b1;
          SYNC_ERR_OE_N <= 1'b1;
        end
        `PFC_ERR_OUTPUT:
        begin
          // open drain: drive low only, release for high
          SYNC_ERR_OUT  <= 1'b0;
          SYNC_ERR_OE_N <= ~STATUS_ERR;
        end
        `PFC_ERR_GPO:
        begin
          SYNC_ERR_OUT  <= control[`PFC_BIT_ERR_LEVEL];
          SYNC_ERR_OE_N <= 1'b0;
        end
        default:
        begin
          SYNC_ERR_OUT  <= 1'b1;
          SYNC_ERR_OE_N <= 1'b1;
        end
      endcase
    end
  end

  // sticky events; a read clears, but a same-cycle event wins
  always @(posedge CLK)
  begin
    if (!RST_N)
    begin
      irq_status <= 3'b000;
      IRQ        <= 1'b0;
    end
    else
    begin
      // bit 2 marks a conversion withheld by a low sync pin
      irq_status <= (irq_status & ~{3{status_read}})
                    | {wait_sync & ~sync_pin,
                       STATUS_ERR | err_in_flag,
                       CONV_START};
      IRQ <= |(irq_status & irq_mask);
    end
  end
endmodule

// ==== dv/pfc_pin_model.sv ====
// pin-level far side: peer drivers and the pull-up on the sync line
// assumes OE_N low means the block drives that pin
`timescale 1ns/100ps
module pfc_pin_model
(
  input  wire clk,
  input  wire oe0_n,
  input  wire out0,
  input  wire oe1_n,
  input  wire out1,
  input  wire ext1,
  input  wire se_oe_n,
  input  wire se_out,
  input  wire peer_low,
  output wire pin0,
  output wire pin1,
  output wire pin_se
);
  reg flip = 1'b0;
  always @(posedge clk)
    flip <= ~flip;
  // undriven pin zero wanders so a stale level never passes
  assign pin0 = oe0_n ? flip : out0;
  assign pin1 = oe1_n ? ext1 : out1;
  // wired line, pull-up: any low driver wins
  assign pin_se = ~(peer_low | (~se_oe_n & ~se_out));
endmodule

// ==== dv/pin_function_control_checker.sv ====
// port assertions for pin function control, with a bus shadow
// assumes a zero-wait slave; control index 0x06, sequencer index 0x08
`timescale 1ns/100ps
module pfc_checker
(
  input wire        CLK,
  input wire        RST_N,
  input wire        HSEL,
  input wire [31:0] HADDR,
  input wire [1:0]  HTRANS,
  input wire        HWRITE,
  input wire [31:0] HWDATA,
  input wire        HREADY,
  input wire [31:0] HRDATA,
  input wire        STATUS_ERR,
  input wire        GP0_OUT,
  input wire        GP0_OE_N,
  input wire        GP1_OUT,
  input wire        GP1_OE_N,
  input wire        SYNC_ERR_IN,
  input wire        SYNC_ERR_OUT,
  input wire        SYNC_ERR_OE_N,
  input wire        CONV_HOLD,
  input wire        CONV_START,
  input wire        CONVERTER_ERROR,
  input wire [1:0]  CHANNEL
);
  reg  [15:0] ctl;
  reg  [15:0] sq;
  reg  [5:0]  wa;
  reg         wr;
  reg         rd6;
  reg  [2:0]  q;
  reg  [2:0]  lo;
  wire        ap = HSEL & HTRANS[1] & HREADY;
  wire [1:0]  md = ctl[10:9];
  wire [3:0]  en = sq[7:4];
  wire        multi = (en & (en - 4'h1)) != 4'h0;
  wire        qt = q > 3'h4;
  wire        low = lo > 3'h4;
  wire        cw = wr & (wa == 6'h06 | wa == 6'h08);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // quiet counter: pins sync and outputs settle after a config write
  always @(posedge CLK)
  begin
    wr <= ap & HWRITE & RST_N;
    wa <= HADDR[7:2];
    rd6 <= ap & !HWRITE & RST_N & HADDR[7:2] == 6'h06;
    q <= (!RST_N | cw) ? 3'h0 : q + (q != 3'h7);
    lo <= (!RST_N | SYNC_ERR_IN) ? 3'h0 : lo + (lo != 3'h7);
    if (!RST_N)
      ctl <= 16'h0800;
    else if (wr & wa == 6'h06)
      ctl <= HWDATA[15:0] & 16'h1FFF;
    if (!RST_N)
      sq <= 16'h0010;
    else if (wr & wa == 6'h08)
      sq <= HWDATA[15:0];
  end
  chk_reserved_zero: assert property (rd6 |-> HRDATA[15:13] == 3'h0)
    else $error("reserved control bits read nonzero");
  chk_gp_direct: assert property (qt && !ctl[12] |->
    GP0_OE_N == !ctl[2] && GP1_OE_N == !ctl[3] &&
    (GP0_OE_N || GP0_OUT == ctl[0]) && (GP1_OE_N || GP1_OUT == ctl[1]))
    else $error("general pin drive differs from control");
  chk_mux_select: assert property (qt && ctl[12] |->
    !GP0_OE_N && !GP1_OE_N && {GP1_OUT, GP0_OUT} == $past(CHANNEL))
    else $error("mux select does not follow channel");
  chk_err_off: assert property (qt && md == 2'b00 |-> SYNC_ERR_OE_N)
    else $error("sync pin driven with error role off");
  chk_err_input: assert property (qt && md == 2'b01 && low |->
    CONVERTER_ERROR && SYNC_ERR_OE_N)
    else $error("low error input not flagged");
  chk_od_high: assert property (qt && md == 2'b10 |->
    SYNC_ERR_OE_N || !SYNC_ERR_OUT)
    else $error("open drain output driven high");
  chk_od_error: assert property (qt && md == 2'b10 && $past(STATUS_ERR)
    && $past(STATUS_ERR, 2) && $past(STATUS_ERR, 3) |-> !SYNC_ERR_OE_N)
    else $error("error not driven low on sync pin");
  chk_gpo_drive: assert property (qt && md == 2'b11 |->
    !SYNC_ERR_OE_N && SYNC_ERR_OUT == ctl[8])
    else $error("sync pin output level wrong");
  chk_sync_hold: assert property (qt && ctl[11] && !sq[0] && low |->
    CONV_HOLD)
    else $error("low sync pin does not hold converter");
  // with a settle delay, a start whose switch came before the pin fell
  // may land while it is low; only the zero-delay case is bounded
  chk_alt_gate: assert property (qt && ctl[11] && sq[0] && multi && low
    |-> !CONV_HOLD && (sq[15:8] != 8'h00 || !CONV_START))
    else $error("alternate sync misbehaves while pin low");
  cover property (qt && ctl[12] && CONV_START);
  cover property (qt && md == 2'b10 && !SYNC_ERR_OE_N);
  cover property (qt && sq[0] && low && multi);
endmodule

bind pin_function_control pfc_checker i_chk
(
  .CLK, .RST_N, .HSEL, .HADDR, .HTRANS, .HWRITE, .HWDATA, .HREADY,
  .HRDATA, .STATUS_ERR, .GP0_OUT, .GP0_OE_N, .GP1_OUT, .GP1_OE_N,
  .SYNC_ERR_IN, .SYNC_ERR_OUT, .SYNC_ERR_OE_N, .CONV_HOLD, .CONV_START,
  .CONVERTER_ERROR, .CHANNEL
);

// ==== dv/pin_function_control_tb_top.sv ====
// bench: AHB-Lite host tasks exercising the pin function control block
// assumes the pin model on the far side and a zero-wait slave
`timescale 1ns/100ps
module pin_function_control_tb_top;
  reg         clk = 1'b0;
  reg         rst_n = 1'b0;
  reg         hsel = 1'b0;
  reg  [31:0] haddr = 32'h0;
  reg  [1:0]  htrans = 2'h0;
  reg         hwrite = 1'b0;
  reg  [31:0] hwdata = 32'h0;
  reg         sw = 1'b0;
  reg         serr = 1'b0;
  reg         ext1 = 1'b0;
  reg         peer = 1'b0;
  reg  [31:0] rv;
  reg  [1:0]  c0;
  integer     n_errors = 0;
  integer     samples_checked = 0;
  integer     cyc = 0;
  integer     n0;
  integer     n6;
  integer     i;
  wire [31:0] hrdata;
  wire [1:0]  chan;
  wire        rdy, gp0o, gp0e, gp1o, gp1e, seo, see, pin0, pin1, pinse;
  wire        hold, start, cerr, irq, hresp;
  initial
    forever #5 clk = ~clk;
  pin_function_control i_dut
  (
    .CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
    .HREADY(rdy), .HRDATA(hrdata), .HREADYOUT(rdy), .HRESP(hresp),
    .SWITCH_REQ(sw), .STATUS_ERR(serr), .GP0_IN(pin0), .GP0_OUT(gp0o),
    .GP0_OE_N(gp0e), .GP1_IN(pin1), .GP1_OUT(gp1o), .GP1_OE_N(gp1e),
    .SYNC_ERR_IN(pinse), .SYNC_ERR_OUT(seo), .SYNC_ERR_OE_N(see),
    .CONV_HOLD(hold), .CONV_START(start), .CONVERTER_ERROR(cerr),
    .CHANNEL(chan), .IRQ(irq)
  );
  pfc_pin_model i_pins
  (
    .clk(clk), .oe0_n(gp0e), .out0(gp0o), .oe1_n(gp1e), .out1(gp1o),
    .ext1(ext1), .se_oe_n(see), .se_out(seo), .peer_low(peer),
    .pin0(pin0), .pin1(pin1), .pin_se(pinse)
  );
  task tick(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task bus(input [7:0] a, input w, input [31:0] d);
    begin
      hsel <= 1'b1;
      // a is the register index; the byte address is four times it
      haddr <= {22'h0, a[5:0], 2'b00};
      htrans <= 2'h2;
      hwrite <= w;
      tick(1);
      while (rdy !== 1'b1) tick(1);
      htrans <= 2'h0;
      hwdata <= d;
      tick(1);
      while (rdy !== 1'b1) tick(1);
      rv = hrdata;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp)
      begin
        n_errors = n_errors + 1;
        $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task wait_start(output integer n);
    begin
      n = 0;
      while (start !== 1'b1 && n < 40)
      begin
        tick(1);
        n = n + 1;
      end
    end
  endtask
  task sw_go(output integer n);
    begin
      sw <= 1'b1;
      tick(1);
      sw <= 1'b0;
      wait_start(n);
    end
  endtask
  task give_verdict;
    begin
      $display("checked %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 5000)
    begin
      n_errors = n_errors + 1;
      give_verdict;
    end
  end
  initial
  begin
    tick(3);
    rst_n <= 1'b1;
    // bit 8 is a live pin readback, so masked here
    bus(8'h06, 0, 0);
    chk(rv & 32'hFFFFFEFF, 32'h0800);
    bus(8'h20, 0, 0);
    chk(rv, 32'h0);
    chk(hresp, 0);
    bus(8'h06, 1, 32'h000D);
    bus(8'h06, 0, 0);
    chk(rv, 32'h010D);
    tick(4);
    chk({gp1e, gp1o, gp0e, gp0o}, 4'h1);
    bus(8'h06, 1, 32'h20);
    ext1 <= 1'b1;
    tick(4);
    bus(8'h06, 0, 0);
    chk(rv, 32'h0122);
    ext1 <= 1'b0;
    tick(4);
    bus(8'h06, 0, 0);
    chk(rv, 32'h0120);
    bus(8'h06, 1, 32'h0700);
    tick(4);
    chk({see, pinse}, 2'h1);
    bus(8'h06, 1, 32'h0400);
    serr <= 1'b1;
    tick(6);
    chk(pinse, 0);
    serr <= 1'b0;
    bus(8'h06, 1, 32'h0200);
    peer <= 1'b1;
    tick(6);
    chk(cerr, 1);
    bus(8'h06, 0, 0);
    chk(rv, 32'h0200);
    bus(8'h06, 1, 32'h0);
    tick(6);
    chk({cerr, see}, 2'h1);
    bus(8'h06, 1, 32'h0800);
    tick(6);
    chk(hold, 1);
    peer <= 1'b0;
    tick(6);
    chk(hold, 0);
    bus(8'h10, 1, 32'h1);
    bus(8'h08, 1, 32'h00F0);
    bus(8'h06, 1, 32'h1000);
    tick(4);
    c0 = chan;
    for (i = 1; i < 5; i = i + 1)
    begin
      sw_go(n0);
      chk(chan, (c0 + i) & 3);
      chk(n0, 3);
    end
    tick(2);
    chk(irq, 1);
    bus(8'h0C, 0, 0);
    chk(rv & 1, 1);
    tick(2);
    chk(irq, 0);
    bus(8'h08, 1, 32'h06F0);
    sw_go(n6);
    chk(n6 - n0, 6);
    bus(8'h10, 1, 32'h0);
    sw_go(n0);
    tick(3);
    chk(irq, 0);
    bus(8'h08, 1, 32'h00F1);
    bus(8'h06, 1, 32'h1800);
    peer <= 1'b1;
    tick(6);
    sw_go(n0);
    chk(n0, 40);
    chk(hold, 0);
    bus(8'h0C, 0, 0);
    chk(rv & 4, 4);
    peer <= 1'b0;
    wait_start(n0);
    chk(start, 1);
    give_verdict;
  end
endmodule
